// ==== rtl/ccppwm_consts.svh ====
// ccppwm_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the pwm design files
`ifndef CCPPWM_CONSTS_SVH
`define CCPPWM_CONSTS_SVH

// apb byte offsets
`define CCPPWM_OFF_CTRL   8'h00
`define CCPPWM_OFF_DUTY   8'h04
`define CCPPWM_OFF_ACTIVE 8'h08
`define CCPPWM_OFF_PERIOD 8'h0C
`define CCPPWM_OFF_TIMER  8'h10
`define CCPPWM_OFF_TCTL   8'h14
`define CCPPWM_OFF_DELAY  8'h18
`define CCPPWM_OFF_SHDN   8'h1C

// reset values
`define CCPPWM_RST_CTRL   8'h00
`define CCPPWM_RST_DUTY   8'h00
`define CCPPWM_RST_PERIOD 8'hFF
`define CCPPWM_RST_TCTL   8'h00
`define CCPPWM_RST_DELAY  8'h00
`define CCPPWM_RST_SHDN   8'h02

// field positions and codes
`define CCPPWM_DLY_RESTART 7
`define CCPPWM_SHDN_FLAG   7
`define CCPPWM_SHDN_DIR    1
`define CCPPWM_SHDN_EN     0
`define CCPPWM_MODE_PWM    2'h3

// timing: pclk is the oscillator, instruction cycle is four of them
`define CCPPWM_TOSC_NS 100
`define CCPPWM_TCY_NS  (4 * `CCPPWM_TOSC_NS)
`define CCPPWM_TCY_CYC (`CCPPWM_TCY_NS / `CCPPWM_TOSC_NS)

`endif

// ==== rtl/ccppwm_pkg.sv ====
// ccppwm_pkg: types shared by the pwm design files
// assumes: nothing beyond the consts header
package ccppwm_pkg;

  // pwm control register layout
  typedef struct packed {
    logic [1:0] rsv;
    logic [1:0] duty_lsb;
    logic [3:0] mode;
  } ccppwm_ctrl_s;

  // period timer control register layout
  typedef struct packed {
    logic       rsv;
    logic [3:0] postscale;
    logic       on;
    logic [1:0] prescale;
  } ccppwm_tctl_s;

  // transition delay states, one-hot
  typedef enum logic [2:0] {
    CCPPWM_DLY_IDLE = 3'b001,
    CCPPWM_DLY_WAIT = 3'b010,
    CCPPWM_DLY_HIGH = 3'b100
  } ccppwm_dly_e;

endpackage

// ==== rtl/ccppwm_delay.sv ====
// ccppwm_delay: holds back each rise of the pwm level by a count of
// instruction cycles; falls pass after one register stage
// assumes: raw_in and delay_count come from logic on pclk
`include "ccppwm_consts.svh"

module ccppwm_delay
  import ccppwm_pkg::*;
(
  input  wire logic       pclk,        // oscillator clock
  input  wire logic       presetn,     // async reset, low
  input  wire logic       ce,          // clock enable
  input  wire logic       raw_in,      // undelayed pwm level
  input  wire logic [6:0] delay_count, // instruction cycles
  output logic            dly_out      // delayed pwm level
);

  ccppwm_dly_e state_reg;
  logic [8:0]  cnt_reg;
  logic [8:0]  load_val;

  // count in oscillator cycles: four per instruction cycle
  assign load_val = 9'(delay_count * `CCPPWM_TCY_CYC) - 9'h001;

  //////////////////////////////////////////////////////////////////////////
  // delay state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= CCPPWM_DLY_IDLE;
      cnt_reg   <= 9'h000;
      dly_out   <= 1'b0;
    end
    else if (ce)
    begin
      case (state_reg)
        CCPPWM_DLY_IDLE:
        begin
          if (raw_in && delay_count == 7'h00)
          begin
            state_reg <= CCPPWM_DLY_HIGH;
            dly_out   <= 1'b1;
          end
          else if (raw_in)
          begin
            state_reg <= CCPPWM_DLY_WAIT;
            cnt_reg   <= load_val;
          end
        end
        CCPPWM_DLY_WAIT:
        begin
          // a pulse shorter than the delay never shows
          if (!raw_in)
            state_reg <= CCPPWM_DLY_IDLE;
          else if (cnt_reg == 9'h000)
          begin
            state_reg <= CCPPWM_DLY_HIGH;
            dly_out   <= 1'b1;
          end
          else
            cnt_reg <= cnt_reg - 9'h001;
        end
        CCPPWM_DLY_HIGH:
        begin
          if (!raw_in)
          begin
            state_reg <= CCPPWM_DLY_IDLE;
            dly_out   <= 1'b0;
          end
        end
        default:
        begin
          state_reg <= CCPPWM_DLY_IDLE;
          dly_out   <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_delay_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_reg == CCPPWM_DLY_WAIT && cnt_reg != 9'h000) |=> !dly_out)
    else $error("output rose before the delay ran out");

  a_delay_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_reg == CCPPWM_DLY_IDLE && raw_in && delay_count == 7'h00)
    |=> dly_out)
    else $error("zero delay did not pass the rise");

endmodule // ccppwm_delay

// ==== rtl/ccppwm_top.sv ====
// ccppwm_top: pwm unit with period timer, buffered duty, restart and
// transition delay, registers on apb
// assumes: pclk is the oscillator; shutdown_in is an asynchronous pin
//
// Operation
// - pin carries a pwm waveform with up to ten bits of duty resolution
// - writing zero to the control register forces the pin latch low
// - period is (period register + 1) times four oscillator cycles times prescale
// - timer at period register value clears on the next increment
// - rollover sets the pin high unless the duty is zero
// - rollover copies the duty buffer into the active duty latch
// - postscaler gives a separate update tick, not the pwm frequency
// - duty is eight buffer bits above control bits 5:4
// - high time is duty times one oscillator cycle times prescale
// - duty writes land any time, take effect after the period ends
// - active duty latch is read-only in pwm mode
// - with restart enabled the shutdown flag clears when the cause goes
// - with restart disabled the flag stays until software clears it
// - each rise is delayed by the seven-bit count of instruction cycles
// - shutdown flag reads one while outputs are held shut down
//
// The APB slave port and the address map were left to the implementer.
`include "ccppwm_consts.svh"

module ccppwm_top
  import ccppwm_pkg::*;
(
  input  wire logic        pclk,            // oscillator clock
  input  wire logic        presetn,         // async reset, low
  input  wire logic        ce,              // clock enable
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb enable
  input  wire logic        pwrite,          // apb direction
  input  wire logic [7:0]  paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error
  input  wire logic        shutdown_in,     // shutdown cause pin
  output logic             pwm_output_pin,  // pwm pin level
  output logic             pwm_output_oe_n, // pin drive, low drives
  output logic             update_tick      // postscaled rollover
);

  ccppwm_ctrl_s ctrl;
  ccppwm_tctl_s tctl;
  logic [7:0]   ctrl_reg;
  logic [7:0]   duty_buffer_register;
  logic [9:0]   active_duty_latch;
  logic [7:0]   period_register;
  logic [7:0]   tctl_reg;
  logic [7:0]   pwm_deadband_delay;
  logic [1:0]   shdn_reg;
  logic         shutdown_event_flag;
  logic [9:0]   fine_reg;
  logic [3:0]   pre_cnt_reg;
  logic [3:0]   post_cnt_reg;
  logic         raw_pwm_reg;
  logic [2:0]   sync_reg;
  logic         sd_level_reg;
  logic         dly_pwm;
  logic [9:0]   duty_next;
  logic [7:0]   period_timer;
  logic         wr_en;
  logic         rd_setup;
  logic         addr_hit;
  logic [7:0]   rd_mux;
  logic         pwm_on;
  logic         pre_tick;
  logic         rollover;
  logic         sd_cond;
  logic         restart_auto_enable;
  logic         sw_flag_clear;

  // prescale code to terminal count: 1, 4 or 16 oscillator cycles
  function automatic logic [3:0] pre_max(input logic [1:0] code);
    case (code)
      2'h0:    pre_max = 4'h0;
      2'h1:    pre_max = 4'h3;
      default: pre_max = 4'hF;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // field views and decode
  assign ctrl                = ccppwm_ctrl_s'(ctrl_reg);
  assign tctl                = ccppwm_tctl_s'(tctl_reg);
  assign duty_next           = {duty_buffer_register, ctrl.duty_lsb};
  assign period_timer        = fine_reg[9:2];
  assign restart_auto_enable = pwm_deadband_delay[`CCPPWM_DLY_RESTART];
  assign pwm_on              = (ctrl.mode[3:2] == `CCPPWM_MODE_PWM) && tctl.on;
  assign pre_tick            = (pre_cnt_reg == pre_max(tctl.prescale));
  // timer equal to period register: next increment restarts it
  assign rollover = pwm_on && pre_tick && (period_timer == period_register)
                    && (fine_reg[1:0] == 2'h3);
  assign sd_cond  = sd_level_reg && shdn_reg[`CCPPWM_SHDN_EN];

  // apb strobes; ce low stalls the bus along with everything else
  assign wr_en    = psel && penable && pwrite && ce;
  assign rd_setup = psel && !penable && !pwrite && ce;
  assign pready   = ce;
  assign pslverr  = psel && penable && !addr_hit;
  assign sw_flag_clear = wr_en && (paddr == `CCPPWM_OFF_SHDN)
                         && !pwdata[`CCPPWM_SHDN_FLAG];

  //////////////////////////////////////////////////////////////////////////
  // read mux, unmapped answers zero with pslverr
  always_comb
  begin
    addr_hit = 1'b1;
    rd_mux   = 8'h00;
    case (paddr)
      `CCPPWM_OFF_CTRL:   rd_mux = ctrl_reg;
      `CCPPWM_OFF_DUTY:   rd_mux = duty_buffer_register;
      `CCPPWM_OFF_ACTIVE: rd_mux = active_duty_latch[9:2];
      `CCPPWM_OFF_PERIOD: rd_mux = period_register;
      `CCPPWM_OFF_TIMER:  rd_mux = period_timer;
      `CCPPWM_OFF_TCTL:   rd_mux = tctl_reg;
      `CCPPWM_OFF_DELAY:  rd_mux = pwm_deadband_delay;
      `CCPPWM_OFF_SHDN:   rd_mux = {shutdown_event_flag, 5'h00, shdn_reg};
      default:            addr_hit = 1'b0;
    endcase
  end

  // read data captured in the setup phase so prdata is a register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= {24'h00_0000, rd_mux};
  end

  //////////////////////////////////////////////////////////////////////////
  // software registers; duty writes only reach the buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg             <= `CCPPWM_RST_CTRL;
      duty_buffer_register <= `CCPPWM_RST_DUTY;
      period_register      <= `CCPPWM_RST_PERIOD;
      tctl_reg             <= `CCPPWM_RST_TCTL;
      pwm_deadband_delay   <= `CCPPWM_RST_DELAY;
      shdn_reg             <= 2'(`CCPPWM_RST_SHDN);
    end
    else if (wr_en)
    begin
      case (paddr)
        `CCPPWM_OFF_CTRL:   ctrl_reg <= pwdata[7:0];
        `CCPPWM_OFF_DUTY:   duty_buffer_register <= pwdata[7:0];
        `CCPPWM_OFF_PERIOD: period_register <= pwdata[7:0];
        `CCPPWM_OFF_TCTL:   tctl_reg <= pwdata[7:0];
        `CCPPWM_OFF_DELAY:  pwm_deadband_delay <= pwdata[7:0];
        `CCPPWM_OFF_SHDN:   shdn_reg <= pwdata[1:0];
        default:            ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shutdown pin: three stages, level accepted when the last two agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_reg     <= 3'h0;
      sd_level_reg <= 1'b0;
    end
    else if (ce)
    begin
      sync_reg <= {sync_reg[1:0], shutdown_in};
      if (sync_reg[1] == sync_reg[2])
        sd_level_reg <= sync_reg[2];
    end
  end

  // shutdown flag: a live cause always wins over any clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shutdown_event_flag <= 1'b0;
    else if (ce)
    begin
      if (sd_cond)
        shutdown_event_flag <= 1'b1;
      else if (restart_auto_enable)
        shutdown_event_flag <= 1'b0;
      else if (sw_flag_clear)
        shutdown_event_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ten-bit time base: timer plus two low bits, stepped each prescale
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fine_reg    <= 10'h000;
      pre_cnt_reg <= 4'h0;
    end
    else if (ce)
    begin
      if (!pwm_on)
      begin
        fine_reg    <= 10'h000;
        pre_cnt_reg <= 4'h0;
      end
      else if (pre_tick)
      begin
        pre_cnt_reg <= 4'h0;
        if (rollover)
          fine_reg <= 10'h000;
        else
          fine_reg <= fine_reg + 10'h001;
      end
      else
        pre_cnt_reg <= pre_cnt_reg + 4'h1;
    end
  end

  // active duty follows the buffer only at rollover; bus cannot write it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_duty_latch <= 10'h000;
    else if (ce && rollover)
      active_duty_latch <= duty_next;
  end

  // raw level: high at rollover unless the duty is zero, low when the time base meets the duty
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      raw_pwm_reg <= 1'b0;
    else if (ce)
    begin
      if (!pwm_on)
        raw_pwm_reg <= 1'b0;
      else if (rollover)
        raw_pwm_reg <= (duty_next != 10'h000);
      else if (pre_tick && 10'(fine_reg + 10'h001) == active_duty_latch)
        raw_pwm_reg <= 1'b0;
    end
  end

  // postscaler only paces update ticks, never the pwm period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      post_cnt_reg <= 4'h0;
      update_tick  <= 1'b0;
    end
    else if (ce)
    begin
      update_tick <= 1'b0;
      if (rollover && post_cnt_reg == tctl.postscale)
      begin
        post_cnt_reg <= 4'h0;
        update_tick  <= 1'b1;
      end
      else if (rollover)
        post_cnt_reg <= post_cnt_reg + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // rise delay, then the pin latch
  ccppwm_delay u_delay (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .raw_in      (raw_pwm_reg),
    .delay_count (pwm_deadband_delay[6:0]),
    .dly_out     (dly_pwm)
  );

  // shutdown holds the pin low; a cleared mode does too
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_output_pin  <= 1'b0;
      pwm_output_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      pwm_output_pin  <= dly_pwm && pwm_on && !shutdown_event_flag;
      pwm_output_oe_n <= shdn_reg[`CCPPWM_SHDN_DIR];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_roll;
    ce && rollover;
  endsequence

  a_timer_clear: assert property (s_roll |=> fine_reg == 10'h000)
    else $error("timer not cleared after match");

  a_duty_copy: assert property (s_roll |=> active_duty_latch == $past(duty_next))
    else $error("active duty not loaded at rollover");

  a_pin_set: assert property (s_roll ##0 duty_next != 10'h000 |=> raw_pwm_reg)
    else $error("level not set at rollover");

  a_zero_duty: assert property (s_roll ##0 duty_next == 10'h000 |=> !raw_pwm_reg)
    else $error("zero duty raised the level");

  a_duty_fall: assert property ((ce && pwm_on && pre_tick && !rollover
    && 10'(fine_reg + 10'h001) == active_duty_latch) |=> !raw_pwm_reg)
    else $error("level not dropped at duty match");

  a_ctrl_zero: assert property ((wr_en && paddr == `CCPPWM_OFF_CTRL
    && pwdata[7:0] == 8'h00) ##1 ce |=> !pwm_output_pin)
    else $error("cleared control left the pin high");

  a_active_ro: assert property ((ce && !rollover) |=> $stable(active_duty_latch))
    else $error("active duty changed without rollover");

  a_timer_step: assert property ((ce && pre_tick && pwm_on && !rollover
    && fine_reg[1:0] == 2'h3) |=> period_timer == $past(period_timer) + 8'h01)
    else $error("timer did not step");

  a_auto_restart: assert property ((ce && restart_auto_enable && !sd_cond)
    |=> !shutdown_event_flag)
    else $error("flag not cleared with restart on");

  a_flag_sticky: assert property ((ce && shutdown_event_flag
    && !restart_auto_enable && !sw_flag_clear) |=> shutdown_event_flag)
    else $error("flag dropped without software");

  a_shut_low: assert property ((ce && shutdown_event_flag) |=> !pwm_output_pin)
    else $error("pin active during shutdown");

endmodule // ccppwm_top

// ==== tb/test_ccp_pwm_with_deadband.sv ====
// test_ccp_pwm_with_deadband: register and waveform tests for the pwm unit
// assumes: ccppwm_top and its consts header reachable, pclk is the oscillator
`include "ccppwm_consts.svh"

module test_ccp_pwm_with_deadband;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        shutdown_in;
  logic        pwm_output_pin;
  logic        pwm_output_oe_n;
  logic        update_tick;
  int          fails;
  int          total_checks;
  int          hi;
  int          per;
  int          n;

  ccppwm_top dut (
    .pclk            (pclk),
    .presetn         (presetn),
    .ce              (ce),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .shutdown_in     (shutdown_in),
    .pwm_output_pin  (pwm_output_pin),
    .pwm_output_oe_n (pwm_output_oe_n),
    .update_tick     (update_tick)
  );

  // 10 mhz oscillator
  always #50 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // apb master: request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 100);
    if (pready !== 1'b1)
    begin
      fails++;
      $display("ERROR %0t bus answer never came", $time);
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, experr});
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // pin observers, sampled on the falling edge where the pin has settled
  task automatic wait_lvl(input logic v, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge pclk);
      cnt++;
    end
    while (pwm_output_pin !== v && cnt < 2000);
    if (pwm_output_pin !== v)
    begin
      fails++;
      $display("ERROR %0t pin level wait ran out", $time);
      tally_and_finish();
    end
  endtask

  // high time and full period of one pulse, in pclk cycles
  task automatic meas();
    int lo;
    wait_lvl(1'b0, lo);
    wait_lvl(1'b1, lo);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, lo);
    per = hi + lo;
  endtask

  task automatic count_hi(input int cycles, output int c);
    c = 0;
    repeat (cycles)
    begin
      @(negedge pclk);
      if (pwm_output_pin !== 1'b0)
        c++;
    end
  endtask

  // raise the cause, look at the held state, drop the cause
  task automatic shut(input logic [7:0] dly, input logic [31:0] after_drop);
    wr(`CCPPWM_OFF_DELAY, dly);
    @(posedge pclk);
    shutdown_in <= 1'b1;
    idle(10);
    rd(`CCPPWM_OFF_SHDN, 32'h81, 1'b0);
    count_hi(60, n);
    check(n, 0);
    @(posedge pclk);
    shutdown_in <= 1'b0;
    idle(10);
    rd(`CCPPWM_OFF_SHDN, after_drop, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence; ce stays high except for one freeze mid-pulse
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    shutdown_in = 1'b0;
    fails = 0;
    total_checks = 0;
    idle(2);
    presetn <= 1'b1;
    // reset values, an unmapped word answers with an error
    rd(`CCPPWM_OFF_CTRL, 32'h00, 1'b0);
    rd(`CCPPWM_OFF_DUTY, 32'h00, 1'b0);
    rd(`CCPPWM_OFF_ACTIVE, 32'h00, 1'b0);
    rd(`CCPPWM_OFF_PERIOD, 32'hFF, 1'b0);
    rd(`CCPPWM_OFF_TIMER, 32'h00, 1'b0);
    rd(`CCPPWM_OFF_TCTL, 32'h00, 1'b0);
    rd(`CCPPWM_OFF_DELAY, 32'h00, 1'b0);
    rd(`CCPPWM_OFF_SHDN, 32'h02, 1'b0);
    rd(8'h20, 32'h00, 1'b1);
    check({31'h0, pwm_output_oe_n}, 32'h1);
    // period 9 gives 40 cycles, duty 5:2 gives 22
    wr(`CCPPWM_OFF_PERIOD, 8'h09);
    wr(`CCPPWM_OFF_DUTY, 8'h05);
    wr(`CCPPWM_OFF_CTRL, 8'h2C);
    wr(`CCPPWM_OFF_TCTL, 8'h04);
    meas();
    check(hi, 22);
    check(per, 40);
    rd(`CCPPWM_OFF_ACTIVE, 32'h05, 1'b0);
    wr(`CCPPWM_OFF_ACTIVE, 8'hAA);
    rd(`CCPPWM_OFF_ACTIVE, 32'h05, 1'b0);
    // a duty write early in a period must wait for the rollover
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wr(`CCPPWM_OFF_DUTY, 8'h07);
    rd(`CCPPWM_OFF_ACTIVE, 32'h05, 1'b0);
    meas();
    check(hi, 30);
    // rises held back by 2 instruction cycles, falls not
    wr(`CCPPWM_OFF_DELAY, 8'h02);
    meas();
    check(hi, 22);
    check(per, 40);
    wr(`CCPPWM_OFF_DELAY, 8'h00);
    // prescale of four stretches both figures
    wr(`CCPPWM_OFF_TCTL, 8'h05);
    meas();
    check(hi, 120);
    check(per, 160);
    // postscale of three: one tick per three periods, period untouched
    wr(`CCPPWM_OFF_TCTL, 8'h14);
    meas();
    n = 0;
    repeat (240)
    begin
      @(negedge pclk);
      if (update_tick === 1'b1)
        n++;
    end
    check(n, 2);
    meas();
    check(per, 40);
    // ce low freezes the pin mid-pulse, then the waveform carries on
    @(posedge pclk);
    ce <= 1'b0;
    count_hi(50, n);
    check(n, 50);
    @(posedge pclk);
    ce <= 1'b1;
    meas();
    check(per, 40);
    // drive the pin, then shutdown with and without automatic restart
    wr(`CCPPWM_OFF_SHDN, 8'h01);
    idle(3);
    check({31'h0, pwm_output_oe_n}, 32'h0);
    shut(8'h80, 32'h01);
    meas();
    check(per, 40);
    shut(8'h00, 32'h81);
    count_hi(60, n);
    check(n, 0);
    wr(`CCPPWM_OFF_SHDN, 8'h01);
    idle(10);
    rd(`CCPPWM_OFF_SHDN, 32'h01, 1'b0);
    meas();
    check(hi, 30);
    // zero duty never sets the pin
    wr(`CCPPWM_OFF_DUTY, 8'h00);
    wr(`CCPPWM_OFF_CTRL, 8'h0C);
    idle(100);
    count_hi(100, n);
    check(n, 0);
    // clearing the control register forces the pin low
    wr(`CCPPWM_OFF_DUTY, 8'h05);
    wr(`CCPPWM_OFF_CTRL, 8'h2C);
    meas();
    wr(`CCPPWM_OFF_CTRL, 8'h00);
    idle(5);
    count_hi(100, n);
    check(n, 0);
    // stopped timer reads zero and ignores writes
    wr(`CCPPWM_OFF_TCTL, 8'h00);
    wr(`CCPPWM_OFF_TIMER, 8'h55);
    rd(`CCPPWM_OFF_TIMER, 32'h00, 1'b0);
    tally_and_finish();
  end

endmodule // test_ccp_pwm_with_deadband
